// ==== dmic_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmic_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Register bus read
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Prefetch request and answer
  input wire logic fetch_valid,
  output logic fetch_ready,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_instr,
  input wire logic supervisor_space_code_bit,
  output logic fetch_done,
  output logic [31:0] fetch_data,
  // External bus
  output logic address_strobe_n,
  output logic [31:0] ext_addr,
  output logic ext_super,
  input wire logic ext_ack,
  input wire logic [31:0] ext_rdata,
  // Disable pin
  input wire logic cache_disable_n
);
  // ********************************************
  // Declarations
  // ********************************************
  dmic_arr_if ai ();
  dmic_pkg::dmic_state_t st_ff, nxt_st;
  logic cache_disable_n_s1_ff, cache_disable_n_s2_ff;
  logic ctl_e_ff, nxt_e, ctl_f_ff, nxt_f, clr_all_ff, nxt_clr_all, clr_one_ff, nxt_clr_one;
  logic [dmic_pkg::IDX_W-1:0] idx_reg_ff, nxt_idx_reg;
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got, wstrb0_ff, nxt_wstrb0;
  logic [31:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] addr_ff, nxt_addr, ext_addr_ff, nxt_ext_addr, data_ff, nxt_data;
  logic sup_ff, nxt_sup, cache_ff, nxt_cache, done_ff, nxt_done, as_n_ff, nxt_as_n;
  logic eff_en, take, hit, cacheable;
  logic [dmic_pkg::TAG_W-1:0] ent_tag;
  logic ent_sup;
  logic [dmic_pkg::LINE_W-1:0] ent_line;
  logic [dmic_pkg::WORD_W-1:0] hit_word, ext_word;

  // ********************************************
  // Stores
  // ********************************************
  dmic_mem u_mem (
    .aclk(aclk),
    .ai(ai.mem)
  );
  dmic_valid u_valid (
    .aclk(aclk),
    .aresetn(aresetn),
    .ai(ai.flags)
  );

  // Disable pin comes from off chip, so it passes two flops first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cache_disable_n_s1_ff <= 1'h1;
      cache_disable_n_s2_ff <= 1'h1;
    end else begin
      cache_disable_n_s1_ff <= cache_disable_n;
      cache_disable_n_s2_ff <= cache_disable_n_s1_ff;
    end
  end

  // ********************************************
  // Register bus slave
  // ********************************************
  // Address and data may come in either order; the write commits once both are held.
  assign awready = !aw_got_ff && !bvalid_ff;
  assign wready = !w_got_ff && !bvalid_ff;
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_e = ctl_e_ff;
    nxt_f = ctl_f_ff;
    nxt_idx_reg = idx_reg_ff;
    nxt_clr_all = 1'b0;
    nxt_clr_one = 1'b0;
    if (awvalid && awready) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w_got = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb0 = wstrb[0];
    end
    if (aw_got_ff && w_got_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = dmic_pkg::RESP_OKAY;
      // All live bits sit in byte lane zero, so other lanes change nothing.
      case (awaddr_ff)
        dmic_pkg::OFF_CTL: begin
          if (wstrb0_ff) begin
            nxt_e = wdata_ff[dmic_pkg::CTL_E];
            nxt_f = wdata_ff[dmic_pkg::CTL_F];
            nxt_clr_all = wdata_ff[dmic_pkg::CTL_C];
            nxt_clr_one = wdata_ff[dmic_pkg::CTL_CE];
          end
        end
        dmic_pkg::OFF_ADDR: begin
          if (wstrb0_ff) begin
            nxt_idx_reg = wdata_ff[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W];
          end
        end
        dmic_pkg::OFF_STAT: begin
          nxt_bresp = dmic_pkg::RESP_OKAY;
        end
        default: begin
          nxt_bresp = dmic_pkg::RESP_DECERR;
        end
      endcase
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Reads answer one cycle after the address is taken; the clear bits always read zero.
  assign arready = !rvalid_ff;
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = dmic_pkg::RESP_OKAY;
      case (araddr)
        dmic_pkg::OFF_CTL: begin
          nxt_rdata[dmic_pkg::CTL_E] = ctl_e_ff;
          nxt_rdata[dmic_pkg::CTL_F] = ctl_f_ff;
        end
        dmic_pkg::OFF_ADDR: begin
          nxt_rdata[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W] = idx_reg_ff;
        end
        dmic_pkg::OFF_STAT: begin
          nxt_rdata[dmic_pkg::STA_EN] = eff_en;
          nxt_rdata[dmic_pkg::STA_DIS] = !cache_disable_n_s2_ff;
          nxt_rdata[dmic_pkg::STA_BUSY] = (st_ff != dmic_pkg::ST_IDLE);
        end
        default: begin
          nxt_rresp = dmic_pkg::RESP_DECERR;
        end
      endcase
    end
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Register bus state; reset turns the cache off and unfreezes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= dmic_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= dmic_pkg::RESP_OKAY;
      ctl_e_ff <= dmic_pkg::RST_E;
      ctl_f_ff <= dmic_pkg::RST_F;
      idx_reg_ff <= dmic_pkg::RST_IDX;
      clr_all_ff <= 1'b0;
      clr_one_ff <= 1'b0;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ctl_e_ff <= nxt_e;
      ctl_f_ff <= nxt_f;
      idx_reg_ff <= nxt_idx_reg;
      clr_all_ff <= nxt_clr_all;
      clr_one_ff <= nxt_clr_one;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ********************************************
  // Fetch sequencer
  // ********************************************
  // Pin low overrides the enable bit; neither path touches the entries.
  assign eff_en = ctl_e_ff && cache_disable_n_s2_ff;
  assign fetch_ready = (st_ff == dmic_pkg::ST_IDLE);
  assign take = fetch_valid && fetch_ready;
  assign cacheable = fetch_instr && eff_en;
  assign ent_tag = ai.rd_data[dmic_pkg::ENT_W-1 -: dmic_pkg::TAG_W];
  assign ent_sup = ai.rd_data[dmic_pkg::LINE_W];
  assign ent_line = ai.rd_data[dmic_pkg::LINE_W-1:0];
  // The full upper address is compared even though a narrow bus would alias it.
  assign hit = (ent_tag == addr_ff[31:dmic_pkg::TAG_LSB]) && (ent_sup == sup_ff)
    && ai.vld[addr_ff[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W]];
  // Bit one low selects the upper, lower-addressed word.
  assign hit_word = addr_ff[dmic_pkg::WSEL_BIT] ? ent_line[15:0] : ent_line[31:16];
  assign ext_word = addr_ff[dmic_pkg::WSEL_BIT] ? ext_rdata[15:0] : ext_rdata[31:16];

  // Array ports: a lookup reads on the take edge, a fill writes on the acknowledge edge.
  assign ai.rd_en = take;
  assign ai.rd_idx = fetch_addr[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W];
  assign ai.wr_en = (st_ff == dmic_pkg::ST_EXT) && ext_ack && cache_ff && !ctl_f_ff;
  assign ai.wr_idx = addr_ff[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W];
  assign ai.wr_data = {addr_ff[31:dmic_pkg::TAG_LSB], sup_ff, ext_rdata};
  assign ai.clr_all = clr_all_ff;
  assign ai.clr_one = clr_one_ff;
  assign ai.clr_idx = idx_reg_ff;

  // Cached fetches look up first; others go straight out.
  always_comb begin
    nxt_st = st_ff;
    nxt_addr = addr_ff;
    nxt_sup = sup_ff;
    nxt_cache = cache_ff;
    nxt_ext_addr = ext_addr_ff;
    nxt_as_n = as_n_ff;
    nxt_data = data_ff;
    nxt_done = 1'b0;
    unique case (st_ff)
      dmic_pkg::ST_IDLE: begin
        if (take) begin
          nxt_addr = fetch_addr;
          nxt_sup = supervisor_space_code_bit;
          nxt_cache = cacheable;
          nxt_ext_addr = fetch_instr ? {fetch_addr[31:2], 2'h0} : fetch_addr;
          if (cacheable) begin
            nxt_st = dmic_pkg::ST_LOOK;
          end else begin
            nxt_st = dmic_pkg::ST_EXT;
            nxt_as_n = 1'b0;
          end
        end
      end
      dmic_pkg::ST_LOOK: begin
        if (hit) begin
          nxt_done = 1'b1;
          nxt_data = {16'h0000, hit_word};
          nxt_st = dmic_pkg::ST_IDLE;
        end else begin
          nxt_as_n = 1'b0;
          nxt_st = dmic_pkg::ST_EXT;
        end
      end
      dmic_pkg::ST_EXT: begin
        if (ext_ack) begin
          nxt_as_n = 1'b1;
          nxt_done = 1'b1;
          nxt_data = fetch_instr_word(cache_ff, ext_word, ext_rdata);
          nxt_st = dmic_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Cacheable instruction answers carry one word; data and uncached answers the whole long word.
  function automatic logic [31:0] fetch_instr_word(input logic is_cached,
    input logic [15:0] word, input logic [31:0] line);
    fetch_instr_word = is_cached ? {16'h0000, word} : line;
  endfunction : fetch_instr_word

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= dmic_pkg::ST_IDLE;
      addr_ff <= 32'h0000_0000;
      sup_ff <= 1'b0;
      cache_ff <= 1'b0;
      ext_addr_ff <= 32'h0000_0000;
      as_n_ff <= 1'b1;
      data_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      addr_ff <= nxt_addr;
      sup_ff <= nxt_sup;
      cache_ff <= nxt_cache;
      ext_addr_ff <= nxt_ext_addr;
      as_n_ff <= nxt_as_n;
      data_ff <= nxt_data;
      done_ff <= nxt_done;
    end
  end

  assign address_strobe_n = as_n_ff;
  assign ext_addr = ext_addr_ff;
  assign ext_super = sup_ff;
  assign fetch_done = done_ff;
  assign fetch_data = data_ff;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence take_cached_s;
    take && cacheable;
  endsequence
  sequence quiet_hit_s;
    (st_ff == dmic_pkg::ST_LOOK && hit) ##1 (done_ff && as_n_ff);
  endsequence

  hit_no_strobe_a: assert property (take_cached_s ##1 hit |-> ##1 (done_ff && as_n_ff))
    else $error("hit raised the strobe or did not complete");
  lookup_first_a: assert property (take_cached_s |=> as_n_ff && st_ff == dmic_pkg::ST_LOOK)
    else $error("external access started before the lookup");
  miss_external_a: assert property ((st_ff == dmic_pkg::ST_LOOK && !hit) |=> !address_strobe_n)
    else $error("miss did not start an external fetch");
  data_bypass_a: assert property ((take && !fetch_instr) |=> st_ff == dmic_pkg::ST_EXT
    && !cache_ff && !address_strobe_n)
    else $error("data access entered the cache");
  no_fill_data_a: assert property (ai.wr_en |-> cache_ff && !ctl_f_ff)
    else $error("fill of an uncacheable or frozen access");
  fill_valid_a: assert property ((st_ff == dmic_pkg::ST_EXT && ext_ack && cache_ff && !ctl_f_ff)
    |=> ai.vld[addr_ff[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W]])
    else $error("fill did not set the valid bit");
  hit_word_a: assert property (quiet_hit_s |-> fetch_data[15:0] == ($past(addr_ff[1], 1)
    ? $past(ent_line[15:0], 1) : $past(ent_line[31:16], 1)))
    else $error("wrong word returned on a hit");
  hit_tag_a: assert property ((st_ff == dmic_pkg::ST_LOOK && (ent_tag != addr_ff[31:dmic_pkg::TAG_LSB]
    || ent_sup != sup_ff)) |=> !address_strobe_n)
    else $error("hit with a mismatching tag");
  pin_disable_a: assert property ((!cache_disable_n_s2_ff && take) |=> st_ff == dmic_pkg::ST_EXT)
    else $error("disabled cache was looked up");
  ctl_reset_a: assert property ($rose(aresetn) |-> !ctl_e_ff && !ctl_f_ff)
    else $error("enable or freeze set after reset");
  clear_read_a: assert property ((arvalid && arready && araddr == dmic_pkg::OFF_CTL) |=>
    rdata[dmic_pkg::CTL_C] == 1'b0 && rdata[dmic_pkg::CTL_CE] == 1'b0)
    else $error("clear bits read back as one");
endmodule : dmic_top
`default_nettype wire

// ==== dmic_pkg.sv ====
`default_nettype none
package dmic_pkg;
  // ********************************************
  // Array geometry
  // ********************************************
  localparam int ENTRIES = 64;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int TAG_LSB = 8;
  localparam int TAG_W = 24;
  localparam int LINE_W = 32;
  localparam int WORD_W = 16;
  localparam int WSEL_BIT = 1;
  localparam int ENT_W = TAG_W + 1 + LINE_W;

  // ********************************************
  // Register map and fields
  // ********************************************
  localparam logic [31:0] OFF_CTL = 32'h0000_0000;
  localparam logic [31:0] OFF_ADDR = 32'h0000_0004;
  localparam logic [31:0] OFF_STAT = 32'h0000_0008;
  localparam int CTL_E = 0;
  localparam int CTL_F = 1;
  localparam int CTL_CE = 2;
  localparam int CTL_C = 3;
  localparam int STA_EN = 0;
  localparam int STA_DIS = 1;
  localparam int STA_BUSY = 2;
  localparam logic RST_E = 1'h0;
  localparam logic RST_F = 1'h0;
  localparam logic [5:0] RST_IDX = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ********************************************
  // Fetch sequencer states
  // ********************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_EXT} dmic_state_t;
endpackage : dmic_pkg
`default_nettype wire

// ==== dmic_arr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Carries array reads, fills and valid-bit updates between the sequencer and its stores.
interface dmic_arr_if;
  logic rd_en;
  logic [dmic_pkg::IDX_W-1:0] rd_idx;
  logic [dmic_pkg::ENT_W-1:0] rd_data;
  logic wr_en;
  logic [dmic_pkg::IDX_W-1:0] wr_idx;
  logic [dmic_pkg::ENT_W-1:0] wr_data;
  logic clr_all;
  logic clr_one;
  logic [dmic_pkg::IDX_W-1:0] clr_idx;
  logic [dmic_pkg::ENTRIES-1:0] vld;
  modport ctrl (output rd_en, rd_idx, wr_en, wr_idx, wr_data, clr_all, clr_one, clr_idx,
                input rd_data, vld);
  modport mem (input rd_en, rd_idx, wr_en, wr_idx, wr_data, output rd_data);
  modport flags (input wr_en, wr_idx, clr_all, clr_one, clr_idx, output vld);
endinterface : dmic_arr_if
`default_nettype wire

// ==== dmic_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmic_mem (
  // Clock
  input wire logic aclk,
  // Array port
  dmic_arr_if.mem ai
);
  // Tag, space bit and line per entry; no reset, the valid bits guard them.
  logic [dmic_pkg::ENT_W-1:0] arr_ff [dmic_pkg::ENTRIES];
  logic [dmic_pkg::ENT_W-1:0] nxt_rd_data;
  logic [dmic_pkg::ENT_W-1:0] rd_data_ff;

  // Read data hold their value between reads.
  always_comb begin
    nxt_rd_data = ai.rd_en ? arr_ff[ai.rd_idx] : rd_data_ff;
  end

  // Fills write the whole entry at once.
  always_ff @(posedge aclk) begin
    rd_data_ff <= nxt_rd_data;
    if (ai.wr_en) begin
      arr_ff[ai.wr_idx] <= ai.wr_data;
    end
  end

  assign ai.rd_data = rd_data_ff;

  default clocking cb @(posedge aclk); endclocking

  // Entries never filled hold unknowns, so the read is matched exactly, unknowns included.
  wr_rd_back_a: assert property ((ai.rd_en && !(ai.wr_en && ai.wr_idx == ai.rd_idx)) |=>
    ai.rd_data === arr_ff[$past(ai.rd_idx)])
    else $error("array read returned the wrong entry");
  fill_stored_a: assert property ((ai.wr_en) |=> arr_ff[$past(ai.wr_idx)] == $past(ai.wr_data))
    else $error("fill did not store the entry");
endmodule : dmic_mem
`default_nettype wire

// ==== dmic_valid.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmic_valid (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Valid-bit port
  dmic_arr_if.flags ai
);
  logic [dmic_pkg::ENTRIES-1:0] vld_ff;
  logic [dmic_pkg::ENTRIES-1:0] nxt_vld;

  // One valid bit per entry; a fill wins over a clear in the same cycle.
  for (genvar i = 0; i < dmic_pkg::ENTRIES; i++) begin : g_ent
    always_comb begin
      if (ai.wr_en && ai.wr_idx == dmic_pkg::IDX_W'(i)) begin
        nxt_vld[i] = 1'b1;
      end else if (ai.clr_all || (ai.clr_one && ai.clr_idx == dmic_pkg::IDX_W'(i))) begin
        nxt_vld[i] = 1'b0;
      end else begin
        nxt_vld[i] = vld_ff[i];
      end
    end
  end

  // Reset leaves the whole array invalid.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vld_ff <= '0;
    end else begin
      vld_ff <= nxt_vld;
    end
  end

  assign ai.vld = vld_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_clears_a: assert property ($rose(aresetn) |-> vld_ff == '0)
    else $error("valid bits not cleared by reset");
  clear_all_a: assert property ((ai.clr_all && !ai.wr_en) |=> vld_ff == '0)
    else $error("clear all left a valid entry");
  keep_valid_a: assert property ((!ai.clr_all && !ai.clr_one) |=>
    (vld_ff & $past(vld_ff)) == $past(vld_ff))
    else $error("valid entry lost without a clear");
endmodule : dmic_valid
`default_nettype wire

// ==== dmic_ext_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External memory seen by the cache
// ****************************************
module dmic_ext_mem (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus from the cache
  input wire logic address_strobe_n,
  input wire logic [31:0] ext_addr,
  output logic ext_ack,
  output logic [31:0] ext_rdata,
  // Pacing and access count
  input wire logic slow,
  output int n_acc
);
  int wait_cnt;

  // Each line is a fixed pattern of its long-word address, so the bench can predict it.
  function automatic logic [31:0] line_of(input logic [31:0] a);
    return {~a[15:2], 2'h1, a[31:16]} ^ 32'h3c5a_0000;
  endfunction : line_of

  // One acknowledge per strobe, after a random wait when slow; idle data toggles every
  // cycle so that a value sampled at the wrong edge never passes by luck.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_ack <= 1'b0;
      ext_rdata <= 32'h5555_aaaa;
      wait_cnt <= 0;
      n_acc <= 0;
    end else if (ext_ack) begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
    end else if (!address_strobe_n && wait_cnt == 0) begin
      ext_ack <= 1'b1;
      ext_rdata <= line_of(ext_addr);
      n_acc <= n_acc + 1;
      wait_cnt <= slow ? int'($urandom % 6) : 0;
    end else begin
      ext_rdata <= ~ext_rdata;
      wait_cnt <= address_strobe_n ? wait_cnt : wait_cnt - 1;
    end
  end
endmodule : dmic_ext_mem
`default_nettype wire

// ==== dmic_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Cache testbench
// ****************************************
module dmic_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, fetch_addr = '0;
  logic [31:0] rdata, fetch_data, ext_addr, ext_rdata;
  logic [2:0] awprot = '0, arprot = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic fetch_valid = 1'b0, fetch_instr = 1'b0, supervisor_space_code_bit = 1'b0;
  logic cache_disable_n = 1'b1, slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fetch_ready, fetch_done;
  logic address_strobe_n, ext_super, ext_ack;
  logic [1:0] bresp, rresp;
  int n_fail = 0, comparisons = 0, n_acc;
  logic en = 1'b0, frz = 1'b0, dis = 1'b0;
  logic [24:0] rtag [64];
  logic [63:0] rv = '0;
  logic [5:0] cidx = '0;

  // Free-running 250 MHz clock.
  always #2 aclk = ~aclk;

  dmic_top dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .fetch_valid, .fetch_ready, .fetch_addr, .fetch_instr,
    .supervisor_space_code_bit, .fetch_done, .fetch_data, .address_strobe_n, .ext_addr,
    .ext_super, .ext_ack, .ext_rdata, .cache_disable_n);
  dmic_ext_mem mem (.aclk, .aresetn, .address_strobe_n, .ext_addr, .ext_ack, .ext_rdata,
    .slow, .n_acc);

  function automatic logic [31:0] line_of(input logic [31:0] a);
    return {~a[15:2], 2'h1, a[31:16]} ^ 32'h3c5a_0000;
  endfunction : line_of

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Address and data are offered together and each is dropped once taken.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    int t;
    ad = 1'b0;
    wd = 1'b0;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && t < 100);
    bready <= 1'b0;
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, bvalid, bresp});
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 100);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {29'h0, 1'b1, er}, {29'h0, rvalid, rresp});
    @(posedge aclk);
  endtask : axi_rd

  // Control write; the clear bits must always read back as zero.
  task automatic ctl(input logic [31:0] d);
    axi_wr(dmic_pkg::OFF_CTL, d, dmic_pkg::RESP_OKAY);
    en = d[dmic_pkg::CTL_E];
    frz = d[dmic_pkg::CTL_F];
    if (d[dmic_pkg::CTL_C]) rv = '0;
    if (d[dmic_pkg::CTL_CE]) rv[cidx] = 1'b0;
    repeat (3) @(posedge aclk);
    axi_rd(dmic_pkg::OFF_CTL, d & 32'h3, dmic_pkg::RESP_OKAY);
  endtask : ctl

  // One fetch checked against the bench's own copy of tags and valid bits.
  task automatic fetch(input logic [31:0] a, input logic ins, input logic sp);
    logic [5:0] i;
    logic cached;
    logic hit;
    logic [31:0] line;
    logic [31:0] exp;
    int acc0;
    int cyc;
    i = a[7:2];
    cached = ins && en && !dis;
    hit = cached && rv[i] && rtag[i] == {a[31:8], sp};
    line = line_of(a);
    exp = !cached ? line : a[1] ? {16'h0, line[15:0]} : {16'h0, line[31:16]};
    acc0 = n_acc;
    cyc = 0;
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    fetch_instr <= ins;
    supervisor_space_code_bit <= sp;
    slow <= 1'($urandom % 2);
    @(posedge aclk);
    while (fetch_ready !== 1'b1) @(posedge aclk);
    fetch_valid <= 1'b0;
    do begin
      @(posedge aclk);
      cyc++;
    end while (fetch_done !== 1'b1 && cyc < 100);
    chk("fetch_data", exp, fetch_data);
    chk("ext_cycles", {31'h0, !hit}, n_acc - acc0);
    chk("fetch_done", 32'h1, {31'h0, fetch_done});
    chk("ext_addr", ins ? {a[31:2], 2'h0} : a, ext_addr);
    chk("ext_super", {31'h0, sp}, {31'h0, ext_super});
    if (hit) chk("hit_latency", 32'd2, cyc);
    if (cached && !hit && !frz) begin
      rv[i] = 1'b1;
      rtag[i] = {a[31:8], sp};
    end
  endtask : fetch

  // Random fetches over eight indices and four tags, two of which differ only in the top byte.
  task automatic rnd(input int n, input logic ins);
    for (int k = 0; k < n; k++) begin
      fetch({($urandom % 2) ? 8'hff : 8'h00, 15'h0, 1'($urandom % 2), 3'h0, 3'($urandom % 8),
             1'($urandom % 2), 1'b0}, ins, 1'($urandom % 4 == 0));
    end
  endtask : rnd

  // Main sequence.
  initial begin
    void'($urandom(36));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(dmic_pkg::OFF_CTL, 32'h0, dmic_pkg::RESP_OKAY);
    axi_rd(32'h40, 32'h0, dmic_pkg::RESP_DECERR);
    axi_wr(32'h40, 32'h1, dmic_pkg::RESP_DECERR);
    rnd(6, 1'b1);
    ctl(32'h1);
    axi_rd(dmic_pkg::OFF_STAT, 32'h1, dmic_pkg::RESP_OKAY);
    for (int k = 0; k < 130; k++) fetch(32'(k % 65) << 2, 1'b1, 1'b0);
    rnd(60, 1'b1);
    rnd(12, 1'b0);
    ctl(32'h3);
    rnd(20, 1'b1);
    ctl(32'h0);
    rnd(10, 1'b1);
    ctl(32'h1);
    rnd(20, 1'b1);
    cache_disable_n <= 1'b0;
    dis = 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(dmic_pkg::OFF_STAT, 32'h2, dmic_pkg::RESP_OKAY);
    rnd(10, 1'b1);
    cache_disable_n <= 1'b1;
    repeat (4) @(posedge aclk);
    dis = 1'b0;
    rnd(20, 1'b1);
    ctl(32'h9);
    rnd(20, 1'b1);
    // Clear one entry through the entry address register and see it miss again.
    fetch(32'h0000_0014, 1'b1, 1'b0);
    axi_wr(dmic_pkg::OFF_ADDR, 32'h0000_0014, dmic_pkg::RESP_OKAY);
    cidx = 6'h05;
    axi_rd(dmic_pkg::OFF_ADDR, 32'h0000_0014, dmic_pkg::RESP_OKAY);
    ctl(32'h5);
    fetch(32'h0000_0014, 1'b1, 1'b0);
    rnd(20, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    en = 1'b0;
    frz = 1'b0;
    rv = '0;
    @(posedge aclk);
    axi_rd(dmic_pkg::OFF_CTL, 32'h0, dmic_pkg::RESP_OKAY);
    ctl(32'h1);
    rnd(20, 1'b1);
    tally_and_finish();
  end

  // The sequence needs a few thousand cycles; the guard allows many times that.
  initial begin
    #(4 * 50000);
    n_fail++;
    tally_and_finish();
  end
endmodule : dmic_top_tb
`default_nettype wire
